// [src/urxb_core.sv]
// Receive error flags, baud generator registers and port 1 pin control
//
// Behaviour
// - Error status clears on reset or when power or receive enable is 0.
// - Error status is byte read-only; writes leave it alone.
// - Bit 2 parity, bit 1 framing, bit 0 overrun; bits 7..3 read zero.
// - Reading error status clears all three flags.
// - Parity flag sets when received parity disagrees with odd or even mode.
// - Parity checking depends on the two-bit parity mode.
// - Framing flag sets when the stop position samples low at completion.
// - Only the first stop bit is checked, whatever the stop setting.
// - Overrun flag sets when a frame completes with the buffer still unread.
// - On overrun the new byte is dropped; the buffer keeps the old one.
// - Error status read inserts one wait cycle.
// - Base select 00 timer, 01 /2, 10 /8, 11 /32.
// - Five-bit divider divides base clock by k, 8..31.
// - Baud rate is the divider output divided by two.
// - Baud control resets to 1F; bit 5 is always zero.
// - Function bit 3 picks port (0) or serial transmit (1); resets to 0.
// - Direction 0 drives, 1 floats; resets FF; bits other than 3,2 read 1.
// - Zero-parity mode never raises the parity flag.
// - Power enable bit 7, receive enable bit 5; power off resets receive and baud logic, not pin function or direction.
`timescale 1ns/1ps
module urxb_core (
  input wire logic mclk,
  input wire logic nrst,
  input wire urxb_pkg::urxb_cpu_t cpu,
  output logic [7:0] cpu_rdata,
  output logic cpu_wait,
  input wire urxb_pkg::urxb_mode_t mode,
  input wire urxb_pkg::urxb_frame_t frame,
  input wire logic rxb_read,
  output logic rxb_load,
  input wire logic timer_channel_output,
  output logic base_tick,
  output logic baud_clk,
  output logic baud_tick,
  input wire logic tx_serial_data,
  input wire logic general_port_bit_three,
  input wire logic general_port_bit_two,
  output logic serial_tx_pin_o,
  output logic serial_tx_pin_oe,
  input wire logic serial_rx_pin_i,
  output logic serial_rx_pin_o,
  output logic serial_rx_pin_oe,
  output logic rx_pin_level
);
  import urxb_pkg::*;

  // ********************************************************************
  // Declarations
  // ********************************************************************
  logic [7:0] func_r;
  logic [7:0] dir_r;
  logic [7:0] baud_r;
  logic [2:0] flags_r;
  logic [2:0] flags_nxt;
  logic rxb_full_r;
  logic rxb_full_nxt;
  logic rxb_load_r;
  logic [7:0] rdata_r;
  urxb_rdstate_t rd_state_r;
  urxb_rdstate_t rd_state_nxt;
  logic rx_s1_r;
  logic rx_s2_r;
  logic rx_level_r;
  logic tx_o_r;
  logic tx_oe_r;
  logic rx_o_r;
  logic rx_oe_r;

  wire logic sel_func;
  wire logic sel_dir;
  wire logic sel_baud;
  wire logic sel_status;
  wire logic rd_taken;
  wire logic status_read;
  wire logic rx_enabled;
  wire logic done_now;
  wire logic pe_hit;
  wire logic fe_hit;
  wire logic ove_hit;
  wire logic [2:0] flags_set;
  wire logic [7:0] status_word;
  wire logic [7:0] rd_word;

  // ********************************************************************
  // Parity check
  // ********************************************************************
  // True when the received parity bit disagrees with odd or even mode
  function automatic logic parity_fault(input urxb_parity_t pm, input logic [7:0] d,
                                        input logic c8, input logic pb);
    logic ones_odd;
    ones_odd = ^{d[7] & c8, d[6:0], pb};
    case (pm)
      PAR_ODD: parity_fault = ~ones_odd;
      PAR_EVEN: parity_fault = ones_odd;
      default: parity_fault = 1'b0;
    endcase
  endfunction

  // ********************************************************************
  // Address decode and read mux
  // ********************************************************************
  assign sel_func = (cpu.addr == ADDR_PIN_FUNC);
  assign sel_dir = (cpu.addr == ADDR_PIN_DIR);
  assign sel_baud = (cpu.addr == ADDR_BAUD_CTRL);
  assign sel_status = (cpu.addr == ADDR_ERR_STATUS);

  // First cycle of a status read is stretched by one wait
  assign cpu_wait = cpu.rd & sel_status & (rd_state_r == RD_IDLE);
  assign rd_taken = cpu.rd & ~cpu_wait;
  assign status_read = rd_taken & sel_status;

  assign status_word = {STATUS_PAD, flags_r};
  assign rd_word = sel_func ? func_r :
                   sel_dir ? dir_r :
                   sel_baud ? baud_r :
                   sel_status ? status_word : 8'h00;

  always_comb begin
    case (rd_state_r)
      RD_IDLE: rd_state_nxt = cpu_wait ? RD_WAIT : RD_IDLE;
      RD_WAIT: rd_state_nxt = RD_IDLE;
      default: rd_state_nxt = RD_IDLE;
    endcase
  end

  // ********************************************************************
  // Error flags
  // ********************************************************************
  // Power and receive enable come from the mode register bits 7 and 5
  assign rx_enabled = mode.power & mode.rx_en;
  assign done_now = rx_enabled & frame.done;
  // Zero and no parity never flag
  assign pe_hit = done_now & parity_fault(mode.parity_mode, frame.data,
                                          frame.char8, frame.parity_bit);
  // Only the first stop position is presented by the shifter
  assign fe_hit = done_now & ~frame.stop_bit;
  assign ove_hit = done_now & rxb_full_r;
  assign flags_set = {pe_hit, fe_hit, ove_hit};

  // Set beats a clear by read so an event in the read cycle survives;
  // bus writes never reach the flags
  assign flags_nxt = !rx_enabled ? RST_ERR_FLAGS :
                     ((status_read ? RST_ERR_FLAGS : flags_r) | flags_set);

  // Unread tracking: a byte in the buffer blocks the next transfer
  assign rxb_full_nxt = !mode.power ? 1'b0 :
                        (done_now & ~rxb_full_r) ? 1'b1 :
                        rxb_read ? 1'b0 : rxb_full_r;

  // ********************************************************************
  // Registers
  // ********************************************************************
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      func_r <= RST_PIN_FUNC;
      dir_r <= RST_PIN_DIR;
      baud_r <= RST_BAUD_CTRL;
    end else if (cpu.wr) begin
      if (sel_func) begin
        func_r <= cpu.wdata & FUNC_WR_MASK;
      end
      if (sel_dir) begin
        dir_r <= cpu.wdata | ~DIR_WR_MASK;
      end
      if (sel_baud) begin
        baud_r <= cpu.wdata & BAUD_WR_MASK;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      flags_r <= RST_ERR_FLAGS;
      rxb_full_r <= 1'b0;
      rxb_load_r <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      rxb_full_r <= rxb_full_nxt;
      rxb_load_r <= done_now & ~rxb_full_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rd_state_r <= RD_IDLE;
      rdata_r <= 8'h00;
    end else begin
      rd_state_r <= rd_state_nxt;
      if (rd_taken) begin
        rdata_r <= rd_word;
      end
    end
  end

  // ********************************************************************
  // Pins
  // ********************************************************************
  // Receive pin is asynchronous; two stages before anything looks at it
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_level_r <= 1'b1;
      tx_o_r <= 1'b0;
      tx_oe_r <= 1'b0;
      rx_o_r <= 1'b0;
      rx_oe_r <= 1'b0;
    end else begin
      rx_s1_r <= serial_rx_pin_i;
      rx_s2_r <= rx_s1_r;
      // Line reads idle high while the port is powered down
      rx_level_r <= mode.power ? rx_s2_r : 1'b1;
      tx_o_r <= func_r[BIT_TX_FUNC] ? tx_serial_data : general_port_bit_three;
      tx_oe_r <= ~dir_r[BIT_TX_DIR];
      rx_o_r <= general_port_bit_two;
      rx_oe_r <= ~dir_r[BIT_RX_DIR];
    end
  end

  // ********************************************************************
  // Baud generator
  // ********************************************************************
  urxb_baud_gen u_baud (
    .mclk(mclk),
    .nrst(nrst),
    .run(mode.power),
    .base_sel(urxb_base_t'(baud_r[7:BAUD_SEL_LSB])),
    .divider(baud_r[BAUD_DIV_MSB:0]),
    .timer_channel_output(timer_channel_output),
    .base_tick(base_tick),
    .baud_clk(baud_clk),
    .baud_tick(baud_tick)
  );

  assign cpu_rdata = rdata_r;
  assign rxb_load = rxb_load_r;
  assign serial_tx_pin_o = tx_o_r;
  assign serial_tx_pin_oe = tx_oe_r;
  assign serial_rx_pin_o = rx_o_r;
  assign serial_rx_pin_oe = rx_oe_r;
  assign rx_pin_level = rx_level_r;

  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  status_layout_a: assert property (
    status_read |=> (cpu_rdata == {STATUS_PAD, $past(flags_r)}))
    else $error("status readback wrong");
  disable_clear_a: assert property (
    !rx_enabled |=> (flags_r == RST_ERR_FLAGS))
    else $error("flags kept while disabled");
  write_ignored_a: assert property (
    (cpu.wr && sel_status && !done_now && !status_read && rx_enabled)
    |=> $stable(flags_r)) else $error("write changed status");
  read_clear_a: assert property (
    (status_read && !done_now && rx_enabled) |=> (flags_r == RST_ERR_FLAGS))
    else $error("read did not clear flags");
  parity_set_a: assert property (
    (done_now && frame.char8 && mode.parity_mode == PAR_EVEN &&
     (^{frame.data, frame.parity_bit})) |=> flags_r[BIT_PARITY_ERR])
    else $error("parity flag missed");
  zero_parity_a: assert property (
    (mode.parity_mode == PAR_ZERO && $stable(mode) && !flags_r[BIT_PARITY_ERR])
    |=> !flags_r[BIT_PARITY_ERR]) else $error("parity flag in zero mode");
  frame_err_a: assert property (
    (done_now && !frame.stop_bit) |=> flags_r[BIT_FRAMING_ERR])
    else $error("framing flag missed");
  overrun_keep_a: assert property (
    (done_now && rxb_full_r) |=> (flags_r[BIT_OVERRUN_ERR] && !rxb_load))
    else $error("overrun not flagged or byte loaded");
  read_wait_a: assert property (
    (cpu.rd && sel_status && rd_state_r == RD_IDLE) |-> cpu_wait ##1 !cpu_wait)
    else $error("status read wait wrong");
  dir_readback_a: assert property (
    (rd_taken && sel_dir) |=> (cpu_rdata[7:4] == 4'hf && cpu_rdata[1:0] == 2'h3))
    else $error("direction fixed bits wrong");
  baud_bit5_a: assert property (
    (rd_taken && sel_baud) |=> !cpu_rdata[5]) else $error("baud bit 5 set");

  overrun_c: cover property (done_now && rxb_full_r);
  parity_c: cover property (pe_hit ##[1:20] status_read);
  framing_c: cover property (fe_hit);
  wait_read_c: cover property (cpu_wait ##1 status_read);

endmodule

// [src/urxb_pkg.sv]
// Shared constants and types for the receive error, baud and pin block
package urxb_pkg;

  // ********************************************************************
  // Register byte addresses
  // ********************************************************************
  localparam logic [15:0] ADDR_PIN_FUNC = 16'hff20;
  localparam logic [15:0] ADDR_PIN_DIR = 16'hff21;
  localparam logic [15:0] ADDR_BAUD_CTRL = 16'hff71;
  localparam logic [15:0] ADDR_ERR_STATUS = 16'hff73;

  // ********************************************************************
  // Reset values and writable masks
  // ********************************************************************
  localparam logic [7:0] RST_PIN_FUNC = 8'h00;
  localparam logic [7:0] RST_PIN_DIR = 8'hff;
  localparam logic [7:0] RST_BAUD_CTRL = 8'h1f;
  localparam logic [2:0] RST_ERR_FLAGS = 3'h0;
  localparam logic [7:0] FUNC_WR_MASK = 8'h08;
  localparam logic [7:0] DIR_WR_MASK = 8'h0c;
  localparam logic [7:0] BAUD_WR_MASK = 8'hdf;
  localparam logic [4:0] STATUS_PAD = 5'h00;

  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int BIT_PARITY_ERR = 2;
  localparam int BIT_FRAMING_ERR = 1;
  localparam int BIT_OVERRUN_ERR = 0;
  localparam int BIT_TX_FUNC = 3;
  localparam int BIT_TX_DIR = 3;
  localparam int BIT_RX_DIR = 2;
  localparam int BAUD_SEL_LSB = 6;
  localparam int BAUD_DIV_MSB = 4;

  // ********************************************************************
  // Divider figures
  // ********************************************************************
  localparam logic [4:0] DIV_MIN = 5'h08;
  localparam logic [4:0] PRE_MASK_DIV2 = 5'h01;
  localparam logic [4:0] PRE_MASK_DIV8 = 5'h07;
  localparam logic [4:0] PRE_MASK_DIV32 = 5'h1f;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [1:0] {PAR_NONE, PAR_ZERO, PAR_ODD, PAR_EVEN} urxb_parity_t;
  typedef enum logic [1:0] {BASE_TIMER, BASE_DIV2, BASE_DIV8, BASE_DIV32} urxb_base_t;
  typedef enum logic {RD_IDLE, RD_WAIT} urxb_rdstate_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } urxb_cpu_t;

  typedef struct packed {
    logic power;
    logic tx_en;
    logic rx_en;
    urxb_parity_t parity_mode;
  } urxb_mode_t;

  typedef struct packed {
    logic done;
    logic char8;
    logic [7:0] data;
    logic parity_bit;
    logic stop_bit;
  } urxb_frame_t;

endpackage

// [src/urxb_baud_gen.sv]
// Base clock prescaler, five-bit divider and final divide by two
`timescale 1ns/1ps
module urxb_baud_gen (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic run,
  input wire urxb_pkg::urxb_base_t base_sel,
  input wire logic [4:0] divider,
  input wire logic timer_channel_output,
  output logic base_tick,
  output logic baud_clk,
  output logic baud_tick
);
  import urxb_pkg::*;

  logic [4:0] pre_r;
  logic [4:0] cnt_r;
  logic tmr_q_r;
  logic base_tick_r;
  logic baud_clk_r;
  logic baud_tick_r;
  wire logic [4:0] pre_mask;
  wire logic base_hit;
  wire logic [4:0] k_eff;
  wire logic cnt_hit;

  // ********************************************************************
  // Base clock selection
  // ********************************************************************
  assign pre_mask = (base_sel == BASE_DIV2) ? PRE_MASK_DIV2 :
                    (base_sel == BASE_DIV8) ? PRE_MASK_DIV8 : PRE_MASK_DIV32;
  // Timer output taken on its rising edge
  assign base_hit = (base_sel == BASE_TIMER) ? (timer_channel_output & ~tmr_q_r) :
                    ((pre_r & pre_mask) == pre_mask);

  // Prohibited settings run as the smallest legal k (8), the fastest rate, instead of a short count
  assign k_eff = (divider < DIV_MIN) ? DIV_MIN : divider;
  assign cnt_hit = base_tick_r && (cnt_r == k_eff - 5'h01);

  always_ff @(posedge mclk) begin
    if (!nrst || !run) begin
      pre_r <= 5'h00;
      cnt_r <= 5'h00;
      tmr_q_r <= 1'b0;
      base_tick_r <= 1'b0;
      baud_clk_r <= 1'b0;
      baud_tick_r <= 1'b0;
    end else begin
      pre_r <= pre_r + 5'h01;
      tmr_q_r <= timer_channel_output;
      base_tick_r <= base_hit;
      if (base_tick_r) begin
        cnt_r <= cnt_hit ? 5'h00 : cnt_r + 5'h01;
      end
      if (cnt_hit) begin
        baud_clk_r <= ~baud_clk_r;
      end
      baud_tick_r <= cnt_hit & baud_clk_r;
    end
  end

  assign base_tick = base_tick_r;
  assign baud_clk = baud_clk_r;
  assign baud_tick = baud_tick_r;

  // ********************************************************************
  // Checks
  // ********************************************************************
  div_range_a: assert property (@(posedge mclk) disable iff (!nrst)
    cnt_r < k_eff) else $error("divider count beyond k");
  half_period_a: assert property (@(posedge mclk) disable iff (!nrst)
    (run && $changed(baud_clk_r)) |-> $past(cnt_hit)) else $error("baud edge without count");
  div2_rate_a: assert property (@(posedge mclk) disable iff (!nrst || !run)
    (base_sel == BASE_DIV2 && $stable(base_sel) && base_tick_r) |=> !base_tick_r)
    else $error("divide by two base too fast");

endmodule

// [testbench/urxb_remote_model.sv]
// Remote serial sender model: shifts a frame on the pin, then flags completion
`timescale 1ns/1ps
module urxb_remote_model (
  input wire logic mclk,
  input wire urxb_pkg::urxb_parity_t parity_mode,
  output urxb_pkg::urxb_frame_t frame,
  output logic serial_rx_pin_i
);
  import urxb_pkg::*;

  // ****************************************************************
  // Idle state
  // ****************************************************************
  initial begin
    frame = '0;
    serial_rx_pin_i = 1'b1;
  end

  // ****************************************************************
  // Frame sender
  // ****************************************************************
  // Line rests high between frames, as a released asynchronous line does
  task automatic send(input logic [7:0] d, input logic bad_par, input logic stop);
    logic pb;
    logic [10:0] bits;
    pb = (parity_mode == PAR_ODD) ? ~^d : (parity_mode == PAR_EVEN) ? ^d : 1'b0;
    pb = pb ^ bad_par;
    bits = {stop, pb, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge mclk);
      serial_rx_pin_i <= bits[i];
    end
    @(posedge mclk);
    serial_rx_pin_i <= 1'b1;
    frame <= '{done: 1'b1, char8: 1'b1, data: d, parity_bit: pb, stop_bit: stop};
    @(posedge mclk);
    frame.done <= 1'b0;
  endtask
endmodule

// [testbench/testbench.sv]
// Self-checking bench for the receive error, baud and pin block
`timescale 1ns/1ps
module testbench;
  import urxb_pkg::*;
  logic mclk, nrst, rxb_read, tco, txd, gp3, gp2, timer_run;
  urxb_cpu_t cpu;
  urxb_mode_t mode;
  urxb_frame_t frame;
  logic [7:0] cpu_rdata, v;
  logic cpu_wait, rxb_load, base_tick, baud_clk, baud_tick, w;
  logic tx_o, tx_oe, rx_i, rx_o, rx_oe, rx_lvl;
  int failures, check_count, loads, l0, per, bases, b0;

  urxb_core uut (.mclk(mclk), .nrst(nrst), .cpu(cpu), .cpu_rdata(cpu_rdata),
    .cpu_wait(cpu_wait), .mode(mode), .frame(frame), .rxb_read(rxb_read),
    .rxb_load(rxb_load), .timer_channel_output(tco), .base_tick(base_tick),
    .baud_clk(baud_clk), .baud_tick(baud_tick), .tx_serial_data(txd),
    .general_port_bit_three(gp3), .general_port_bit_two(gp2),
    .serial_tx_pin_o(tx_o), .serial_tx_pin_oe(tx_oe), .serial_rx_pin_i(rx_i),
    .serial_rx_pin_o(rx_o), .serial_rx_pin_oe(rx_oe), .rx_pin_level(rx_lvl));
  urxb_remote_model partner (.mclk(mclk), .parity_mode(mode.parity_mode),
    .frame(frame), .serial_rx_pin_i(rx_i));

  // ****************************************************************
  // Clock, timer source and load counter
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (timer_run) tco <= ~tco;
    if (rxb_load === 1'b1) loads++;
    if (base_tick === 1'b1) bases++;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic chk_int(input int got, input int exp, input string msg);
    check_count++;
    if (got != exp) begin
      failures++;
      $display("[FAIL] t=%0t %s got %0d exp %0d", $time, msg, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    cpu <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    cpu.wr <= 1'b0;
  endtask
  // Read held until the wait state has passed; data sampled after the taking edge
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic wt);
    int n;
    @(posedge mclk);
    cpu <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(negedge mclk);
    wt = cpu_wait;
    n = 0;
    while (cpu_wait !== 1'b0 && n < 4) begin
      @(negedge mclk);
      n++;
    end
    @(posedge mclk);
    cpu.rd <= 1'b0;
    @(negedge mclk);
    d = cpu_rdata;
  endtask
  task automatic set_mode(input logic p, input logic r, input urxb_parity_t pm);
    @(posedge mclk);
    mode <= '{power: p, tx_en: 1'b0, rx_en: r, parity_mode: pm};
    repeat (4) @(posedge mclk);
  endtask
  task automatic buf_read();
    @(posedge mclk);
    rxb_read <= 1'b1;
    @(posedge mclk);
    rxb_read <= 1'b0;
  endtask
  // Synchronised pin shows the start bit three cycles after it is driven
  task automatic send_lvl(input logic [7:0] d, input logic s, input logic lvl);
    fork
      partner.send(d, 1'b0, s);
      begin
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        chk8({7'h00, rx_lvl}, {7'h00, lvl}, "rx pin level");
      end
    join
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    rd(ADDR_PIN_FUNC, v, w); chk8(v, 8'h00, "func reset");
    rd(ADDR_PIN_DIR, v, w); chk8(v, 8'hff, "dir reset");
    rd(ADDR_BAUD_CTRL, v, w); chk8(v, 8'h1f, "baud reset");
    rd(ADDR_ERR_STATUS, v, w); chk8(v, 8'h00, "status reset");
    rd(16'hff22, v, w); chk8(v, 8'h00, "unmapped read");
  endtask
  task automatic t_masks();
    wr(ADDR_BAUD_CTRL, 8'hff); rd(ADDR_BAUD_CTRL, v, w); chk8(v, 8'hdf, "baud bit5");
    wr(ADDR_PIN_DIR, 8'h00); rd(ADDR_PIN_DIR, v, w); chk8(v, 8'hf3, "dir fixed");
    wr(ADDR_PIN_FUNC, 8'hff); rd(ADDR_PIN_FUNC, v, w); chk8(v, 8'h08, "func mask");
    wr(ADDR_ERR_STATUS, 8'hff); rd(ADDR_ERR_STATUS, v, w); chk8(v, 8'h00, "status wr");
    wr(ADDR_PIN_FUNC, 8'h00);
    wr(ADDR_PIN_DIR, 8'hff); // Receive pin left as input
  endtask
  task automatic t_framing();
    set_mode(1'b1, 1'b1, PAR_NONE);
    l0 = loads;
    send_lvl(8'h3c, 1'b0, 1'b0);
    repeat (2) @(posedge mclk);
    rd(ADDR_ERR_STATUS, v, w);
    chk8({7'h00, w}, 8'h01, "status wait");
    chk8(v, 8'h02, "framing flag");
    chk_int(loads - l0, 1, "buffer load");
    rd(ADDR_ERR_STATUS, v, w); chk8(v, 8'h00, "read clears");
    buf_read();
  endtask
  task automatic t_parity();
    for (int m = 0; m < 4; m++) begin
      for (int b = 0; b < 2; b++) begin
        set_mode(1'b1, 1'b0, urxb_parity_t'(m)); // Mode changed with reception off
        set_mode(1'b1, 1'b1, urxb_parity_t'(m));
        partner.send(8'h55, b[0], 1'b1);
        repeat (2) @(posedge mclk);
        rd(ADDR_ERR_STATUS, v, w);
        chk8(v, (b == 1 && m >= 2) ? 8'h04 : 8'h00, "parity flag");
        buf_read();
      end
    end
  endtask
  task automatic t_overrun();
    l0 = loads;
    partner.send(8'h11, 1'b0, 1'b1);
    partner.send(8'h22, 1'b0, 1'b1);
    repeat (2) @(posedge mclk);
    rd(ADDR_ERR_STATUS, v, w); chk8(v, 8'h01, "overrun flag");
    chk_int(loads - l0, 1, "second byte dropped");
    buf_read();
  endtask
  task automatic t_disable();
    for (int i = 0; i < 2; i++) begin
      set_mode(1'b1, 1'b1, PAR_NONE);
      partner.send(8'h0f, 1'b0, 1'b0);
      set_mode(i == 0, 1'b0, PAR_NONE);
      send_lvl(8'h0f, 1'b0, i != 0); // Pin forced high while powered down
      rd(ADDR_ERR_STATUS, v, w); chk8(v, 8'h00, "disable clears");
    end
  endtask
  // Timer toggles every cycle, so its base period is two clocks
  task automatic t_baud();
    int pre[5] = '{2, 8, 32, 2, 2};
    logic [1:0] sel[5] = '{2'b01, 2'b10, 2'b11, 2'b00, 2'b01};
    logic [4:0] k[5] = '{5'd9, 5'd9, 5'd9, 5'd9, 5'd31};
    timer_run <= 1'b1; // Timer running before it is picked
    for (int i = 0; i < 5; i++) begin
      // Powered down so the divider restarts from zero under the new k
      set_mode(1'b0, 1'b0, PAR_NONE);
      wr(ADDR_BAUD_CTRL, {sel[i], 1'b0, k[i]}); // Both directions off
      set_mode(1'b1, 1'b0, PAR_NONE);
      repeat (2) begin
        per = 1;
        b0 = bases;
        @(negedge mclk);
        while (baud_tick !== 1'b1 && per < 2000) begin
          @(negedge mclk);
          per++;
        end
      end
      chk_int(per, pre[i] * k[i] * 2, "baud period");
      chk_int(bases - b0, k[i] * 2, "base ticks per baud");
      chk8({7'h00, baud_clk}, 8'h00, "baud clock at tick");
    end
  endtask
  task automatic t_pins();
    wr(ADDR_PIN_FUNC, 8'h08);
    wr(ADDR_PIN_DIR, 8'hf3); // Transmit direction cleared for output
    txd <= 1'b1;
    gp2 <= 1'b1;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk8({6'h00, tx_oe, tx_o}, 8'h03, "tx serial drive");
    chk8({6'h00, rx_oe, rx_o}, 8'h03, "rx pin drive");
    @(posedge mclk);
    txd <= 1'b0;
    gp3 <= 1'b1;
    wr(ADDR_PIN_FUNC, 8'h00);
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk8({7'h00, tx_o}, 8'h01, "tx port latch");
    wr(ADDR_PIN_DIR, 8'hff);
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk8({6'h00, tx_oe, rx_oe}, 8'h00, "buffers off");
  endtask

  // ****************************************************************
  // Verdict, watchdog and main sequence
  // ****************************************************************
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge mclk);
    failures++;
    give_verdict();
  end
  initial begin
    nrst = 1'b0;
    cpu = '0;
    mode = '0;
    rxb_read = 1'b0;
    tco = 1'b0;
    txd = 1'b0;
    gp3 = 1'b0;
    gp2 = 1'b0;
    timer_run = 1'b0;
    failures = 0;
    check_count = 0;
    loads = 0;
    bases = 0;
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    t_reset();
    t_masks();
    t_framing();
    t_parity();
    t_overrun();
    t_disable();
    t_baud();
    t_pins();
    give_verdict();
  end
endmodule
